// >>> rtl/hfc_bridge.sv
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Frame buffer reads use one 4-dword line
// - Hard or soft reset empties the line
// - Missing read completes in ten cycles
// - Hit read completes in two cycles
// - Frame buffer writes flush the line
// - Legacy register writes flush the line
// - ROM, palette, external reads flush
// - Legacy window read, legacy mode flushes
// - Config changes never flush; software must
// - Config space is never swapped
// - Power up little endian, swaps off
// - Boot ROM bytes pass untranslated
// - I/O accesses are bytes, unswapped
// - Swap enable swaps register space dwords
// - Legacy, palette, external data unswapped
// - Swap by pixel size, address unchanged
// - Direct size code selects swap mode
// - 8-bit code keeps lanes unchanged
// - Transfer size field swaps image moves
// - Host pixel layouts follow listed formats
// - Packed 24-bit pixels straddle dwords
module hfc_bridge (
   input  wire logic                  clk_in,
   input  wire logic                  rst_n_in,
   input  wire logic                  soft_rst_in,
   input  wire logic                  psel_in,
   input  wire logic                  penable_in,
   input  wire logic                  pwrite_in,
   input  wire logic [7:0]            paddr_in,
   input  wire logic [31:0]           pwdata_in,
   output logic      [31:0]           prdata_out,
   output logic                       pready_out,
   output logic                       pslverr_out,
   input  wire hfc_pkg::hfc_host_req_t hst_req_in,
   output logic                       hst_ack_out,
   output logic      [31:0]           hst_rdata_out,
   output hfc_pkg::hfc_dev_req_t      dev_req_out,
   input  wire logic [31:0]           dev_rdata_in
);
   // Whole state of the bridge
   typedef struct packed {
      hfc_pkg::hfc_state_t   st;       // Engine state
      logic [3:0]            cnt;      // Cycles since accept
      logic [1:0]            kind;     // 0 pass, 1 hit, 2 fill
      logic                  keep;     // Line survives fill
      logic                  valid;    // Line holds data
      logic [27:0]           tag;      // Line address, bits 31:4
      logic [3:0][31:0]      line;     // Cached dwords
      logic [1:0]            widx;     // Requested dword
      logic [1:0]            rmode;    // Read swap mode
      logic                  ack;      // Host answer
      logic [31:0]           rdata;    // Host read data
      hfc_pkg::hfc_dev_req_t dev;      // Device request
      logic [5:0]            ctrl;     // Control register
      logic [15:0]           hits;     // Hit counter
      logic [31:0]           prdata;   // APB read data
   } hfc_st_t;

   localparam logic [1:0] K_PASS = 2'h0;
   localparam logic [1:0] K_HIT  = 2'h1;
   localparam logic [1:0] K_FILL = 2'h2;

   hfc_st_t     s_r;          // Registered state
   hfc_st_t     s_nxt;        // Next state
   logic        acc;          // Request taken now
   logic        is_fb;        // Frame buffer space
   logic        legacy_rd;    // Uncacheable window read
   logic        hit;          // Request hits line
   logic [1:0]  wmode;        // Write swap mode
   logic [31:0] wdata_sw;     // Swapped write data
   logic [31:0] rsrc;         // Read data before swap
   logic [31:0] rdata_sw;     // Swapped read data
   logic        apb_ok;       // Mapped APB address

   // Swap mode chosen by space and control bits
   function automatic logic [1:0] swap_mode(
      input hfc_pkg::hfc_space_t sp,
      input logic [5:0]          c
   );
      logic [1:0] sz;
      sz = SZ_PICK(sp, c);
      case (sz)
         hfc_pkg::SZ_16: swap_mode = hfc_pkg::SW_16;
         hfc_pkg::SZ_32: swap_mode = hfc_pkg::SW_32;
         default:        swap_mode = hfc_pkg::SW_NONE;
      endcase
   endfunction : swap_mode

   // Effective data size code for a space
   function automatic logic [1:0] SZ_PICK(
      input hfc_pkg::hfc_space_t sp,
      input logic [5:0]          c
   );
      case (sp)
         // Direct size for aperture and window
         hfc_pkg::SP_FB_AP,
         hfc_pkg::SP_FB_WIN: SZ_PICK = c[hfc_pkg::CTRL_DIR+:2];
         hfc_pkg::SP_XFER:   SZ_PICK = c[hfc_pkg::CTRL_XFER+:2];
         hfc_pkg::SP_REG:    SZ_PICK = c[hfc_pkg::CTRL_BE] ?
                                       hfc_pkg::SZ_32 : hfc_pkg::SZ_8;
         default:            SZ_PICK = hfc_pkg::SZ_8;
      endcase
   endfunction : SZ_PICK

   // Write path swapper
   hfc_swap u_wswap (
      .mode_in  (wmode),
      .data_in  (hst_req_in.wdata),
      .data_out (wdata_sw)
   );

   // Read path swapper
   hfc_swap u_rswap (
      .mode_in  (s_r.rmode),
      .data_in  (rsrc),
      .data_out (rdata_sw)
   );

   // Request decode
   always_comb begin
      wmode     = swap_mode(hst_req_in.space, s_r.ctrl);
      is_fb     = (hst_req_in.space == hfc_pkg::SP_FB_AP) ||
                  (hst_req_in.space == hfc_pkg::SP_FB_WIN);
      // Legacy mode window reads bypass line
      legacy_rd = (hst_req_in.space == hfc_pkg::SP_FB_WIN) &&
                  !s_r.ctrl[hfc_pkg::CTRL_NATIVE];
      acc       = (s_r.st == hfc_pkg::ST_IDLE) &&
                  hst_req_in.valid && !s_r.ack;
      hit       = is_fb && !hst_req_in.wr && !legacy_rd &&
                  s_r.valid && (s_r.tag == hst_req_in.addr[31:4]);
      // Cached word or device data
      rsrc      = (s_r.kind == K_PASS) ? dev_rdata_in :
                  s_r.line[s_r.widx];
      apb_ok    = (paddr_in == hfc_pkg::OFS_CTRL) ||
                  (paddr_in == hfc_pkg::OFS_STAT) ||
                  (paddr_in == hfc_pkg::OFS_HITS);
   end

   // Next state
   always_comb begin
      s_nxt         = s_r;
      s_nxt.ack     = 1'b0;
      s_nxt.dev.rd  = 1'b0;
      s_nxt.dev.wr  = 1'b0;
      // APB setup: latch read data
      if (psel_in && !penable_in) begin
         case (paddr_in)
            hfc_pkg::OFS_CTRL: s_nxt.prdata = {26'h0, s_r.ctrl};
            hfc_pkg::OFS_STAT: s_nxt.prdata = {29'h0, s_r.kind,
                                 s_r.valid};
            hfc_pkg::OFS_HITS: s_nxt.prdata = {16'h0, s_r.hits};
            default:           s_nxt.prdata = 32'h0;
         endcase
      end
      // APB access: control write
      if (psel_in && penable_in && pwrite_in &&
          (paddr_in == hfc_pkg::OFS_CTRL)) begin
         s_nxt.ctrl = pwdata_in[hfc_pkg::CTRL_W-1:0];
      end
      case (s_r.st)
         // Wait for a host request
         hfc_pkg::ST_IDLE: begin
            if (acc) begin
               s_nxt.st    = hfc_pkg::ST_BUSY;
               s_nxt.cnt   = 4'h1;
               s_nxt.widx  = hst_req_in.addr[3:2];
               s_nxt.rmode = wmode;
               if (hit) begin
                  s_nxt.kind = K_HIT;
                  s_nxt.hits = s_r.hits + 16'h1;
               end else if (is_fb && !hst_req_in.wr) begin
                  s_nxt.kind      = K_FILL;
                  s_nxt.keep      = !legacy_rd;
                  s_nxt.valid     = 1'b0;
                  s_nxt.tag       = hst_req_in.addr[31:4];
                  s_nxt.dev.rd    = 1'b1;
                  s_nxt.dev.space = hst_req_in.space;
                  s_nxt.dev.addr  = {hst_req_in.addr[31:4], 4'h0};
               end else begin
                  s_nxt.kind      = K_PASS;
                  s_nxt.dev.rd    = !hst_req_in.wr;
                  s_nxt.dev.wr    = hst_req_in.wr;
                  s_nxt.dev.space = hst_req_in.space;
                  s_nxt.dev.addr  = hst_req_in.addr;
                  s_nxt.dev.wdata = wdata_sw;
                  if (hst_req_in.wr && (is_fb ||
                      hst_req_in.space == hfc_pkg::SP_VGAREG ||
                      hst_req_in.space == hfc_pkg::SP_IO)) begin
                     s_nxt.valid = 1'b0;
                  end
                  if (!hst_req_in.wr &&
                      (hst_req_in.space == hfc_pkg::SP_ROM ||
                       hst_req_in.space == hfc_pkg::SP_DAC ||
                       hst_req_in.space == hfc_pkg::SP_EXT)) begin
                     s_nxt.valid = 1'b0;
                  end
               end
            end
         end
         // Count through the access
         hfc_pkg::ST_BUSY: begin
            s_nxt.cnt = s_r.cnt + 4'h1;
            case (s_r.kind)
               K_FILL: begin
                  // Issue the next three dwords
                  if (s_r.cnt <= hfc_pkg::FILL_ISS_END) begin
                     s_nxt.dev.rd   = 1'b1;
                     s_nxt.dev.addr = s_r.dev.addr + 32'h4;
                  end
                  // Capture each dword one cycle later
                  if (s_r.cnt >= hfc_pkg::FILL_CAP_BEG &&
                      s_r.cnt <= hfc_pkg::FILL_CAP_END) begin
                     s_nxt.line[2'(s_r.cnt - 4'h2)] = dev_rdata_in;
                  end
                  if (s_r.cnt == hfc_pkg::MISS_CYC - 4'h1) begin
                     s_nxt.ack   = 1'b1;
                     s_nxt.rdata = rdata_sw;
                     s_nxt.valid = s_r.keep;
                     s_nxt.st    = hfc_pkg::ST_IDLE;
                  end
               end
               K_HIT: begin
                  if (s_r.cnt == hfc_pkg::HIT_CYC - 4'h1) begin
                     s_nxt.ack   = 1'b1;
                     s_nxt.rdata = rdata_sw;
                     s_nxt.st    = hfc_pkg::ST_IDLE;
                  end
               end
               default: begin
                  // Device answers one cycle after issue
                  if (s_r.cnt == hfc_pkg::PASS_CYC - 4'h1) begin
                     s_nxt.ack   = 1'b1;
                     s_nxt.rdata = rdata_sw;
                     s_nxt.st    = hfc_pkg::ST_IDLE;
                  end
               end
            endcase
         end
         // Recover from an illegal code
         default: begin
            s_nxt.st = hfc_pkg::ST_IDLE;
         end
      endcase
      // Soft reset aborts and empties line
      if (soft_rst_in) begin
         s_nxt.st    = hfc_pkg::ST_IDLE;
         s_nxt.valid = 1'b0;
         s_nxt.ack   = 1'b0;
         s_nxt.dev   = '0;
      end
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s_r       <= '0;
         s_r.st    <= hfc_pkg::ST_IDLE;
         s_r.valid <= 1'b0;
         s_r.ctrl  <= hfc_pkg::CTRL_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs
   assign hst_ack_out   = s_r.ack;
   assign hst_rdata_out = s_r.rdata;
   assign dev_req_out   = s_r.dev;
   assign prdata_out    = s_r.prdata;
   assign pready_out    = 1'b1;
   assign pslverr_out   = psel_in && penable_in && !apb_ok;

   // Helpers for checks
   logic acc_miss;   // Fill started
   logic acc_hit;    // Hit started
   assign acc_miss = acc && !hit && is_fb && !hst_req_in.wr;
   assign acc_hit  = acc && hit;

   AST_MISS_TEN: assert property (
      @(posedge clk_in) disable iff (!rst_n_in || soft_rst_in)
      acc_miss |-> ##1 (!s_r.ack)[*8] ##1 !s_r.ack ##1 s_r.ack)
      else $error("miss answer not on tenth cycle");

   AST_HIT_TWO: assert property (
      @(posedge clk_in) disable iff (!rst_n_in || soft_rst_in)
      acc_hit |-> ##1 !s_r.ack ##1 (s_r.ack &&
                  s_r.rdata == rdata_sw && s_r.kind == K_HIT))
      else $error("hit answer not on second cycle");

   AST_FB_WR_FLUSH: assert property (
      @(posedge clk_in) disable iff (!rst_n_in || soft_rst_in)
      acc && is_fb && hst_req_in.wr |=> !s_r.valid [*2])
      else $error("frame buffer write kept line");

   AST_REG_WR_FLUSH: assert property (
      @(posedge clk_in) disable iff (!rst_n_in || soft_rst_in)
      acc && hst_req_in.wr &&
      (hst_req_in.space inside {hfc_pkg::SP_IO,
       hfc_pkg::SP_VGAREG}) |=> !s_r.valid)
      else $error("legacy register write kept line");

   AST_RD_FLUSH: assert property (
      @(posedge clk_in) disable iff (!rst_n_in || soft_rst_in)
      acc && !hst_req_in.wr &&
      (hst_req_in.space inside {hfc_pkg::SP_ROM,
       hfc_pkg::SP_DAC, hfc_pkg::SP_EXT}) |=> !s_r.valid)
      else $error("flushing read kept line");

   AST_LEGACY_RD: assert property (
      @(posedge clk_in) disable iff (!rst_n_in || soft_rst_in)
      acc && legacy_rd && !hst_req_in.wr |-> ##10 !s_r.valid)
      else $error("legacy window read left line valid");

   AST_SOFT_RST: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      soft_rst_in |=> !s_r.valid && s_r.st == hfc_pkg::ST_IDLE)
      else $error("soft reset did not empty line");

   AST_RAW_SPACES: assert property (
      @(posedge clk_in) disable iff (!rst_n_in || soft_rst_in)
      acc && hst_req_in.wr && (hst_req_in.space inside
      {hfc_pkg::SP_CFG, hfc_pkg::SP_ROM, hfc_pkg::SP_IO})
      |=> s_r.dev.wdata == $past(hst_req_in.wdata))
      else $error("raw space data was swapped");

   AST_REG_SWAP: assert property (
      @(posedge clk_in) disable iff (!rst_n_in || soft_rst_in)
      acc && hst_req_in.wr && s_r.ctrl[hfc_pkg::CTRL_BE] &&
      hst_req_in.space == hfc_pkg::SP_REG
      |=> s_r.dev.wdata[7:0] == $past(hst_req_in.wdata[31:24]))
      else $error("register space not dword swapped");

   AST_CTRL_RST: assert property (
      @(posedge clk_in) $rose(rst_n_in) |->
      s_r.ctrl == hfc_pkg::CTRL_RST)
      else $error("control not reset to little endian");

   COV_MISS: cover property (@(posedge clk_in) acc_miss);
   COV_HIT: cover property (@(posedge clk_in) acc_hit);
   COV_HIT_AFTER_MISS: cover property (@(posedge clk_in)
      acc_miss ##12 acc_hit);
endmodule : hfc_bridge
`default_nettype wire

// >>> rtl/hfc_pkg.sv
package hfc_pkg;
   // Data and line geometry
   localparam int DW         = 32;
   localparam int LINE_WORDS = 4;
   localparam int AW         = 8;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_HITS = 8'h08;
   // Control field positions
   localparam int CTRL_BE     = 0;
   localparam int CTRL_NATIVE = 1;
   localparam int CTRL_DIR    = 2;
   localparam int CTRL_XFER   = 4;
   localparam int CTRL_W      = 6;
   // Control reset: little endian, swaps off
   localparam logic [5:0] CTRL_RST = 6'h00;
   // Data size codes
   localparam logic [1:0] SZ_8  = 2'h0;
   localparam logic [1:0] SZ_16 = 2'h1;
   localparam logic [1:0] SZ_32 = 2'h2;
   // Cycle counts, in clock cycles
   localparam logic [3:0] MISS_CYC = 4'hA;
   localparam logic [3:0] HIT_CYC  = 4'h2;
   localparam logic [3:0] PASS_CYC = 4'h3;
   // Fill: issue window and capture window
   localparam logic [3:0] FILL_ISS_END = 4'h3;
   localparam logic [3:0] FILL_CAP_BEG = 4'h2;
   localparam logic [3:0] FILL_CAP_END = 4'h5;
   // Host address spaces
   typedef enum logic [3:0] {
      SP_CFG    = 4'h0,
      SP_ROM    = 4'h1,
      SP_IO     = 4'h2,
      SP_REG    = 4'h3,
      SP_VGAREG = 4'h4,
      SP_DAC    = 4'h5,
      SP_EXT    = 4'h6,
      SP_FB_AP  = 4'h7,
      SP_FB_WIN = 4'h8,
      SP_XFER   = 4'h9
   } hfc_space_t;
   // Byte swap modes
   typedef enum logic [1:0] {
      SW_NONE = 2'h0,
      SW_16   = 2'h1,
      SW_32   = 2'h2
   } hfc_swap_t;
   // Engine states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } hfc_state_t;
   // Host request carrier
   typedef struct packed {
      logic             valid;
      logic             wr;
      hfc_space_t       space;
      logic [31:0]      addr;
      logic [DW-1:0]    wdata;
   } hfc_host_req_t;
   // Device side request carrier
   typedef struct packed {
      logic             rd;
      logic             wr;
      hfc_space_t       space;
      logic [31:0]      addr;
      logic [DW-1:0]    wdata;
   } hfc_dev_req_t;
endpackage : hfc_pkg

// >>> rtl/hfc_swap.sv
`timescale 1ns/10ps
`default_nettype none
// Byte lane swapper, pure combinational
module hfc_swap (
   input  wire logic [1:0]  mode_in,
   input  wire logic [31:0] data_in,
   output logic      [31:0] data_out
);
   // Lane permutation per mode
   always_comb begin
      case (hfc_pkg::hfc_swap_t'(mode_in))
         hfc_pkg::SW_32: begin
            data_out = {data_in[7:0], data_in[15:8],
                        data_in[23:16], data_in[31:24]};
         end
         hfc_pkg::SW_16: begin
            data_out = {data_in[23:16], data_in[31:24],
                        data_in[7:0], data_in[15:8]};
         end
         default: begin
            data_out = data_in;
         end
      endcase
   end
endmodule : hfc_swap
`default_nettype wire

// >>> dv/hfc_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// Device side storage behind the bridge, one word per dword address
module hfc_mem_model (
   input  wire logic                  clk_in,
   input  wire hfc_pkg::hfc_dev_req_t req_in,
   output logic      [31:0]           rdata_out
);
   logic [31:0] mem [64];  // Word storage, all spaces share it
   // Start empty and quiet
   initial begin
      for (int i = 0; i < 64; i++) mem[i] = 32'h0;
      rdata_out = 32'h0;
   end
   // Read answers one cycle after the strobe, otherwise noise
   always @(posedge clk_in) begin
      if (req_in.wr) mem[req_in.addr[7:2]] <= req_in.wdata;
      if (req_in.rd) rdata_out <= mem[req_in.addr[7:2]];
      else rdata_out <= ~rdata_out;
   end
endmodule : hfc_mem_model
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
// Bridge bench: directed corners plus random frame buffer traffic
module tb;
   logic                   clk_in, rst_n_in, soft_rst_in;
   logic                   psel_in, penable_in, pwrite_in;
   logic [7:0]             paddr_in;
   logic [31:0]            pwdata_in, prdata_out, hst_rdata_out;
   logic [31:0]            dev_rdata_in, seed, r, d;
   logic                   pready_out, pslverr_out, hst_ack_out, e;
   logic                   line_ok;         // Bench view of line
   logic [1:0]             tag;             // Cached line number
   logic [31:0]            shadow [16];     // Expected memory
   hfc_pkg::hfc_host_req_t hst_req_in;
   hfc_pkg::hfc_dev_req_t  dev_req_out;
   hfc_pkg::hfc_space_t    sp [6];
   int                     failures, num_checks, i, k;

   hfc_bridge DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .soft_rst_in(soft_rst_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in),
      .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .hst_req_in(hst_req_in),
      .hst_ack_out(hst_ack_out), .hst_rdata_out(hst_rdata_out),
      .dev_req_out(dev_req_out), .dev_rdata_in(dev_rdata_in));
   hfc_mem_model MEM (.clk_in(clk_in), .req_in(dev_req_out),
      .rdata_out(dev_rdata_in));

   // Clock, 100 ns period
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   // Pseudo random step
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   // Expected lane order for a size code
   function automatic logic [31:0] sw(input logic [1:0] m,
                                      input logic [31:0] v);
      case (m)
         2'h1: return {v[23:16], v[31:24], v[7:0], v[15:8]};
         2'h2: return {v[7:0], v[15:8], v[23:16], v[31:24]};
         default: return v;
      endcase
   endfunction : sw

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] v);
      int n;
      @(posedge clk_in);
      psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= w;
      paddr_in <= a; pwdata_in <= v;
      @(posedge clk_in);
      penable_in <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 50);
      r = prdata_out; e = pslverr_out;
      if (pready_out !== 1'b1) failures++;
      psel_in <= 1'b0; penable_in <= 1'b0;
   endtask : apb

   // Control write: swap enable, native flag, sizes
   task automatic ctl(input logic be, input logic nat,
                      input logic [1:0] dir, input logic [1:0] xf);
      apb(1'b1, hfc_pkg::OFS_CTRL, {26'h0, xf, dir, nat, be});
   endtask : ctl

   // Host access: check cycles from take to ack, and read data
   task automatic acc(input logic w, input hfc_pkg::hfc_space_t s,
                      input logic [7:0] a, input logic [31:0] v,
                      input int ec, input logic [31:0] ed);
      int n;
      @(posedge clk_in);
      hst_req_in <= '{1'b1, w, s, {24'h0, a}, v};
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (hst_ack_out !== 1'b1 && n < 40);
      hst_req_in.valid <= 1'b0;
      chk(32'(n - 1), 32'(ec));
      if (!w) chk(hst_rdata_out, ed);
   endtask : acc

   // Closing verdict
   task automatic end_of_test();
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   // Watchdog against hangs
   initial begin
      repeat (20000) @(posedge clk_in);
      failures++;
      end_of_test();
   end

   // Main sequence
   initial begin
      rst_n_in = 1'b0; soft_rst_in = 1'b0; psel_in = 1'b0;
      penable_in = 1'b0; pwrite_in = 1'b0; paddr_in = 8'h00;
      pwdata_in = 32'h0; hst_req_in = '0; failures = 0;
      num_checks = 0; seed = 32'hE7DB;
      sp = '{hfc_pkg::SP_VGAREG, hfc_pkg::SP_IO, hfc_pkg::SP_ROM,
             hfc_pkg::SP_DAC, hfc_pkg::SP_EXT, hfc_pkg::SP_FB_WIN};
      repeat (8) @(posedge clk_in);
      rst_n_in <= 1'b1;
      apb(1'b0, hfc_pkg::OFS_CTRL, 32'h0);
      chk(r, 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
      chk({31'h0, e}, 32'h1);
      // Fill storage through frame buffer writes
      for (i = 0; i < 16; i++) begin
         seed = xs(seed);
         shadow[i] = seed;
         acc(1'b1, hfc_pkg::SP_FB_AP, 8'(i * 4), seed, 3, 0);
      end
      acc(1'b0, hfc_pkg::SP_FB_AP, 8'h10, 0, 10, shadow[4]);
      for (i = 1; i < 4; i++)
         acc(1'b0, hfc_pkg::SP_FB_AP, 8'(16 + i * 4), 0, 2,
             shadow[4 + i]);
      // Three hits counted, last access a hit on a valid line
      apb(1'b0, hfc_pkg::OFS_HITS, 32'h0);
      chk(r, 32'h3);
      apb(1'b0, hfc_pkg::OFS_STAT, 32'h0);
      chk(r, 32'h3);
      // Each flushing access forces a refill
      for (i = 0; i < 6; i++) begin
         acc(i < 2 || i == 5, sp[i], 8'h3C, shadow[15], 3,
             shadow[15]);
         acc(1'b0, hfc_pkg::SP_FB_AP, 8'h14, 0, 10, shadow[5]);
      end
      // Legacy window reads in legacy mode never leave a line
      acc(1'b0, hfc_pkg::SP_FB_WIN, 8'h14, 0, 10, shadow[5]);
      acc(1'b0, hfc_pkg::SP_FB_WIN, 8'h18, 0, 10, shadow[6]);
      ctl(1'b0, 1'b1, 2'h0, 2'h0);
      acc(1'b0, hfc_pkg::SP_FB_WIN, 8'h14, 0, 10, shadow[5]);
      acc(1'b0, hfc_pkg::SP_FB_WIN, 8'h18, 0, 2, shadow[6]);
      // Software must flush after config changes
      ctl(1'b0, 1'b1, 2'h0, 2'h1);
      acc(1'b0, hfc_pkg::SP_FB_AP, 8'h1C, 0, 2, shadow[7]);
      soft_rst_in <= 1'b1;
      @(posedge clk_in);
      soft_rst_in <= 1'b0;
      acc(1'b0, hfc_pkg::SP_FB_AP, 8'h14, 0, 10, shadow[5]);
      // Direct size codes pick the lane order
      for (i = 0; i < 3; i++) begin
         ctl(1'b0, 1'b1, 2'(i), 2'h0);
         acc(1'b0, hfc_pkg::SP_FB_AP, 8'h14, 0, 2,
             sw(2'(i), shadow[5]));
      end
      seed = xs(seed);
      acc(1'b1, hfc_pkg::SP_FB_AP, 8'h20, seed, 3, 0);
      shadow[8] = sw(2'h2, seed);
      ctl(1'b0, 1'b1, 2'h0, 2'h0);
      acc(1'b0, hfc_pkg::SP_FB_AP, 8'h20, 0, 10, shadow[8]);
      // Register and other spaces with swap enable set
      ctl(1'b1, 1'b1, 2'h2, 2'h2);
      acc(1'b1, hfc_pkg::SP_REG, 8'h3C, sw(2'h2, shadow[15]), 3, 0);
      sp = '{hfc_pkg::SP_REG, hfc_pkg::SP_CFG, hfc_pkg::SP_ROM,
             hfc_pkg::SP_IO, hfc_pkg::SP_DAC, hfc_pkg::SP_XFER};
      for (i = 0; i < 6; i++)
         acc(1'b0, sp[i], 8'h3C, 0, 3, (i == 0 || i == 5) ?
             sw(2'h2, shadow[15]) : shadow[15]);
      // Transfer size 10 only in general modes; here blit order
      ctl(1'b0, 1'b1, 2'h0, 2'h1);
      acc(1'b0, hfc_pkg::SP_XFER, 8'h3C, 0, 3,
          sw(2'h1, shadow[15]));
      acc(1'b0, hfc_pkg::SP_REG, 8'h3C, 0, 3, shadow[15]);
      // Random frame buffer traffic, no 24-bit big endian use
      line_ok = 1'b0;
      tag = 2'h0;
      for (i = 0; i < 40; i++) begin
         seed = xs(seed);
         k = int'(seed[5:2]);
         if (seed[8] & seed[9]) begin
            d = xs(seed);
            shadow[k] = d;
            acc(1'b1, hfc_pkg::SP_FB_AP, 8'(k * 4), d, 3, 0);
            line_ok = 1'b0;
         end else begin
            acc(1'b0, hfc_pkg::SP_FB_AP, 8'(k * 4), 0,
                (line_ok && tag == seed[5:4]) ? 2 : 10,
                shadow[k]);
            line_ok = 1'b1;
            tag = seed[5:4];
         end
      end
      end_of_test();
   end
endmodule : tb
`default_nettype wire
